/* hdl/usrt_core.v */
// serial receiver-transmitter with fifos, register file on classic wishbone
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "usrt_defines.vh"
// Function
// - enable bits gate seven interrupt sources
// - line control bit7 maps divisor latches
// - divisor kept as two byte latches
// - line control sets length stop parity break
// - modem control drives dtr rts loopback
// - control bits choose clock source, async
// - control sets fifo thresholds and unit reset
// - 128-entry special character bitmap
// - pointer selects entry, command marks it
// - status write bit7 enables receiver
// - status bit4 shows transmit room
// - tx count falling to threshold flags
// - identification bits 3:1 name top cause
// - status shows head character flags
// - rx count at or above threshold flags
// - long-resident character raises timeout
// - rx entry holds data, special, parity
module usrt_core #(
   parameter DEPTH = 16,
   parameter AW = 4,
   parameter TIMEOUT = `USRT_RX_TIMEOUT
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [5:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // line side
   input wire baud_source_clock_i,
   input wire rx_clk_i,
   input wire rxd_i,
   input wire cts_n_i,
   input wire dsr_n_i,
   output reg txd_o,
   output reg dtr_n_o,
   output reg rts_n_o,
   output wire irq_o
);
   // =============================================
   // pin synchronisers: three flops, change once last two agree
   localparam NP = 5;
   wire [NP-1:0] pin_raw;
   reg [NP-1:0] s1_q, s2_q, s3_q, pin_q;
   assign pin_raw = {dsr_n_i, cts_n_i, rxd_i, rx_clk_i, baud_source_clock_i};
   genvar g;
   generate
      for (g = 0; g < NP; g = g + 1)
      begin : g_sync
         always @(posedge clk_i)
         begin
            if (rst_i)
            begin
               s1_q[g] <= 1'b1;
               s2_q[g] <= 1'b1;
               s3_q[g] <= 1'b1;
               pin_q[g] <= 1'b1;
            end
            else
            begin
               s1_q[g] <= pin_raw[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g])
                  pin_q[g] <= s3_q[g];
            end
         end
      end
   endgenerate
   reg [NP-1:0] pin_d1_q;
   wire bsc_edge = pin_q[0] & ~pin_d1_q[0];
   wire rxc_edge = pin_q[1] & ~pin_d1_q[1];

   // =============================================
   // registers
   reg [7:0] ier_q, lcr_q, mcr_q, ctl_q;
   reg [15:0] div_q;
   reg [6:0] bmp_q;
   reg [127:0] bitmap_q;
   reg rx_en_q, srst_q;
   reg pe_q, oe_q, bi_q, sc_q, to_q, txthr_q, dcts_q, ddsr_q;
   reg [3:0] iid;
   wire rst_all = rst_i | srst_q;
   wire req = cyc_i & stb_i & ~ack_o;
   wire wr = req & we_i & sel_i[0];
   wire rd = req & ~we_i;
   wire dlab = lcr_q[`USRT_LCR_DLAB];

   // =============================================
   // fifos
   reg [9:0] rxm [0:DEPTH-1];
   reg [7:0] txm [0:DEPTH-1];
   reg [AW-1:0] rxw_q, rxr_q, txw_q, txr_q;
   reg [AW:0] rxn_q, txn_q;
   wire rx_empty = (rxn_q == {(AW+1){1'b0}});
   wire rx_full = (rxn_q == DEPTH[AW:0]);
   wire tx_empty = (txn_q == {(AW+1){1'b0}});
   wire tx_room = (txn_q != DEPTH[AW:0]);
   wire [9:0] rx_head = rxm[rxr_q];
   wire rx_pop = rd & ~dlab & (adr_i == `USRT_A_DATA) & ~rx_empty;
   wire tx_push = wr & ~dlab & (adr_i == `USRT_A_DATA) & tx_room;
   wire rx_thr = ~rx_empty & (rxn_q >= {{(AW-1){1'b0}}, ctl_q[4:3]});

   // =============================================
   // baud generator
   reg [15:0] bcnt_q;
   reg tick_q;
   always @(posedge clk_i)
   begin
      if (rst_all)
      begin
         bcnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= 1'b0;
         if (bsc_edge)
         begin
            // a divisor of zero behaves as one, so the output never stalls
            if (bcnt_q + 16'h0001 >= div_q)
            begin
               bcnt_q <= 16'h0000;
               tick_q <= 1'b1;
            end
            else
               bcnt_q <= bcnt_q + 16'h0001;
         end
      end
   end
   wire rx_tick = ctl_q[`USRT_CTL_RXINT] ? tick_q : rxc_edge;
   wire tx_tick = ctl_q[`USRT_CTL_TXINT] ? tick_q : rxc_edge;

   // =============================================
   // transmitter: whole frame built at load, shifted lsb first
   reg [11:0] tfr_q;
   reg [3:0] tbits_q, tovs_q;
   reg tbusy_q;
   wire [2:0] clen = {1'b0, lcr_q[1:0]} + 3'h4;
   wire [7:0] tdat = txm[txr_q] & (8'hFF >> (3'h7 - clen));
   wire tpar = lcr_q[`USRT_LCR_STICK] ? ~lcr_q[`USRT_LCR_EPS] : (^tdat ^ ~lcr_q[`USRT_LCR_EPS]);
   wire tx_pop = ~tbusy_q & ~tx_empty & tx_tick;
   // parity sits right after the last data bit, stop bits fill the rest
   wire [3:0] tpos = {1'b0, clen} + 4'h2;
   wire [11:0] tbase = {3'h0, tdat, 1'b0};
   wire [11:0] tfr_ins = lcr_q[`USRT_LCR_PEN] ?
                         (tbase | ({11'h000, tpar} << tpos) | (12'hFFF << (tpos + 4'h1)))
                       : (tbase | (12'hFFF << tpos));
   always @(posedge clk_i)
   begin
      if (rst_all)
      begin
         tfr_q <= 12'hFFF;
         tbits_q <= 4'h0;
         tovs_q <= 4'h0;
         tbusy_q <= 1'b0;
      end
      else if (tx_pop)
      begin
         tfr_q <= tfr_ins;
         // start + data + optional parity + one or two stops
         tbits_q <= {1'b0, clen} + 4'h3 + {3'h0, lcr_q[`USRT_LCR_PEN]} + {3'h0, lcr_q[`USRT_LCR_STOP]};
         tovs_q <= 4'h0;
         tbusy_q <= 1'b1;
      end
      else if (tbusy_q & tx_tick)
      begin
         tovs_q <= tovs_q + 4'h1;
         if (tovs_q == `USRT_OVS_LAST)
         begin
            tfr_q <= {1'b1, tfr_q[11:1]};
            tbits_q <= tbits_q - 4'h1;
            if (tbits_q == 4'h1)
               tbusy_q <= 1'b0;
         end
      end
   end
   wire tx_line = tfr_q[0] & ~lcr_q[`USRT_LCR_BRK];

   // =============================================
   // receiver: start checked at mid bit, then one sample per bit
   // loopback ties the receiver to the transmitter
   wire rxd = mcr_q[`USRT_MCR_LOOP] ? tx_line : pin_q[2];
   reg [10:0] rsh_q;
   reg [3:0] rbits_q, rovs_q;
   reg rbusy_q, rdone_q;
   wire [3:0] rtotal = {1'b0, clen} + 4'h2 + {3'h0, lcr_q[`USRT_LCR_PEN]};
   always @(posedge clk_i)
   begin
      if (rst_all)
      begin
         rsh_q <= 11'h000;
         rbits_q <= 4'h0;
         rovs_q <= 4'h0;
         rbusy_q <= 1'b0;
         rdone_q <= 1'b0;
      end
      else
      begin
         rdone_q <= 1'b0;
         if (rx_tick & rx_en_q)
         begin
            if (!rbusy_q)
            begin
               rovs_q <= 4'h0;
               rbits_q <= 4'h0;
               if (!rxd)
                  rbusy_q <= 1'b1;
            end
            else
            begin
               rovs_q <= rovs_q + 4'h1;
               if (rovs_q == `USRT_OVS_MID)
               begin
                  if (rbits_q == 4'h0 && rxd)
                     rbusy_q <= 1'b0;
                  rsh_q <= {rxd, rsh_q[10:1]};
                  rbits_q <= rbits_q + 4'h1;
                  if (rbits_q + 4'h1 == rtotal)
                  begin
                     rbusy_q <= 1'b0;
                     rdone_q <= 1'b1;
                  end
               end
            end
         end
      end
   end
   // align the frame so that the start bit sits at bit 0 and data starts at bit 1
   wire [10:0] rfr = rsh_q >> (4'hB - rtotal);
   wire [7:0] rdat = rfr[8:1] & (8'hFF >> (3'h7 - clen));
   // index kept four bits wide so that long characters do not wrap it
   wire rpbit = rfr[{1'b0, clen} + 4'h2];
   wire rpexp = lcr_q[`USRT_LCR_STICK] ? ~lcr_q[`USRT_LCR_EPS] : (^rdat ^ ~lcr_q[`USRT_LCR_EPS]);
   wire rperr = lcr_q[`USRT_LCR_PEN] & (rpbit != rpexp);
   wire rbrk = (rfr == 11'h000);
   // bitmap classifies by low seven bits
   wire rspec = bitmap_q[rdat[6:0]];
   wire rx_push = rdone_q & ~rx_full & ~rbrk;

   // =============================================
   // fifo pointers, flags and timeout
   reg [11:0] tocnt_q;
   always @(posedge clk_i)
   begin
      if (rst_all)
      begin
         rxw_q <= {AW{1'b0}};
         rxr_q <= {AW{1'b0}};
         rxn_q <= {(AW+1){1'b0}};
         txw_q <= {AW{1'b0}};
         txr_q <= {AW{1'b0}};
         txn_q <= {(AW+1){1'b0}};
         tocnt_q <= 12'h000;
         to_q <= 1'b0;
         txthr_q <= 1'b0;
      end
      else
      begin
         if (rx_push)
         begin
            // data with special and parity flags
            rxm[rxw_q] <= {rperr, rspec, rdat};
            rxw_q <= rxw_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (rx_pop)
            rxr_q <= rxr_q + {{(AW-1){1'b0}}, 1'b1};
         rxn_q <= rxn_q + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, rx_pop};
         if (tx_push)
         begin
            txm[txw_q] <= dat_i[7:0];
            txw_q <= txw_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (tx_pop)
            txr_q <= txr_q + {{(AW-1){1'b0}}, 1'b1};
         txn_q <= txn_q + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_pop};
         // set on decrement to threshold, set wins over clear
         if (tx_pop & ~tx_push & (txn_q - {{AW{1'b0}}, 1'b1} == {{(AW-1){1'b0}}, ctl_q[6:5]}))
            txthr_q <= 1'b1;
         else if (tx_push | (rd & adr_i == `USRT_A_IID & iid[3:1] == `USRT_ID_TXT & ~iid[0]))
            txthr_q <= 1'b0;
         // counts receive clocks while a character waits
         if (rx_push | rx_pop | rx_empty)
            tocnt_q <= 12'h000;
         // counter parks one past the limit, so a read never meets a repeated set
         else if (rx_tick & (tocnt_q != TIMEOUT[11:0] + 12'h001))
            tocnt_q <= tocnt_q + 12'h001;
         if (rx_tick & ~rx_empty & (tocnt_q == TIMEOUT[11:0]))
            to_q <= 1'b1;
         else if (rx_pop)
            to_q <= 1'b0;
      end
   end

   // =============================================
   // interrupt priority
   wire ls_pend = (ier_q[`USRT_IE_LS] & (pe_q | oe_q | bi_q)) | (ier_q[`USRT_IE_SC] & sc_q);
   wire ms_pend = ier_q[`USRT_IE_MS] & (dcts_q | ddsr_q);
   always @*
   begin
      // each source gated by its enable
      // highest pending cause in bits 3:1
      iid = 4'h1;
      if (ls_pend)
         iid = {`USRT_ID_LS, 1'b0};
      else if (ier_q[`USRT_IE_TO] & to_q)
         iid = {`USRT_ID_TO, 1'b0};
      else if (ier_q[`USRT_IE_RXT] & rx_thr)
         iid = {`USRT_ID_RXT, 1'b0};
      else if (ier_q[`USRT_IE_TXT] & txthr_q)
         iid = {`USRT_ID_TXT, 1'b0};
      else if (ier_q[`USRT_IE_TSE] & tx_empty & ~tbusy_q)
         iid = {`USRT_ID_TSE, 1'b0};
      else if (ms_pend)
         iid = {`USRT_ID_MS, 1'b0};
   end
   assign irq_o = ~iid[0];

   // =============================================
   // register writes, sticky line and modem flags
   always @(posedge clk_i)
   begin
      if (rst_all)
      begin
         ier_q <= `USRT_RST_8;
         lcr_q <= `USRT_RST_8;
         mcr_q <= `USRT_RST_8;
         ctl_q <= `USRT_RST_8;
         div_q <= `USRT_RST_DIV;
         bmp_q <= 7'h00;
         bitmap_q <= {128{1'b0}};
         rx_en_q <= 1'b0;
         pe_q <= 1'b0;
         oe_q <= 1'b0;
         bi_q <= 1'b0;
         sc_q <= 1'b0;
         dcts_q <= 1'b0;
         ddsr_q <= 1'b0;
         pin_d1_q <= {NP{1'b1}};
      end
      else
      begin
         pin_d1_q <= pin_q;
         if (wr)
         begin
            case (adr_i)
               `USRT_A_DATA: if (dlab) div_q[7:0] <= dat_i[7:0];
               `USRT_A_IER:
               begin
                  if (dlab)
                     div_q[15:8] <= dat_i[7:0];
                  else
                     ier_q <= {1'b0, dat_i[6:0]};
               end
               `USRT_A_LCR: lcr_q <= dat_i[7:0];
               `USRT_A_MCR: mcr_q <= dat_i[7:0] & 8'h13;
               // thresholds held, reset bit never stored
               `USRT_A_CTL: ctl_q <= {1'b0, dat_i[6:0]};
               `USRT_A_STAT: rx_en_q <= dat_i[`USRT_STAT_RXEN];
               `USRT_A_BMP: bmp_q <= dat_i[6:0];
               `USRT_A_BMC: bitmap_q[bmp_q] <= dat_i[`USRT_BMC_MARK];
               default: ;
            endcase
         end
         // sticky flags: a new event in the read cycle survives
         pe_q <= (rx_push & rperr) | (pe_q & ~(rd & adr_i == `USRT_A_LSR));
         sc_q <= (rx_push & rspec) | (sc_q & ~(rd & adr_i == `USRT_A_LSR));
         bi_q <= (rdone_q & rbrk) | (bi_q & ~(rd & adr_i == `USRT_A_LSR));
         oe_q <= (rdone_q & rx_full) | (oe_q & ~(rd & adr_i == `USRT_A_LSR));
         dcts_q <= (pin_q[3] ^ pin_d1_q[3]) | (dcts_q & ~(rd & adr_i == `USRT_A_MSR));
         ddsr_q <= (pin_q[4] ^ pin_d1_q[4]) | (ddsr_q & ~(rd & adr_i == `USRT_A_MSR));
      end
   end

   // =============================================
   // unit reset pulse, bus answer and read data
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         srst_q <= 1'b0;
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
         txd_o <= 1'b1;
         dtr_n_o <= 1'b1;
         rts_n_o <= 1'b1;
      end
      else
      begin
         // control bit7 resets all but the pin synchronisers and the registers of this block for one cycle
         srst_q <= wr & (adr_i == `USRT_A_CTL) & dat_i[`USRT_CTL_RST];
         ack_o <= req;
         // loopback keeps the line idle and modem outputs inactive
         txd_o <= mcr_q[`USRT_MCR_LOOP] | tx_line;
         // modem outputs, active low on the pins
         dtr_n_o <= ~mcr_q[`USRT_MCR_DTR] | mcr_q[`USRT_MCR_LOOP];
         rts_n_o <= ~mcr_q[`USRT_MCR_RTS] | mcr_q[`USRT_MCR_LOOP];
         if (rd)
         begin
            case (adr_i)
               `USRT_A_DATA: dat_o <= {24'h000000, dlab ? div_q[7:0] : rx_head[7:0]};
               `USRT_A_IER: dat_o <= {24'h000000, dlab ? div_q[15:8] : ier_q};
               `USRT_A_IID: dat_o <= {28'h0000000, iid};
               `USRT_A_LCR: dat_o <= {24'h000000, lcr_q};
               `USRT_A_MCR: dat_o <= {24'h000000, mcr_q};
               `USRT_A_LSR: dat_o <= {25'h0000000, tx_empty & ~tbusy_q, sc_q, bi_q, 1'b0, pe_q, oe_q, ~rx_empty};
               `USRT_A_MSR: dat_o <= {26'h0000000, ~pin_q[4], ~pin_q[3], 2'b00, ddsr_q, dcts_q};
               `USRT_A_CTL: dat_o <= {24'h000000, ctl_q};
               // head character flags shown before the read
               `USRT_A_STAT: dat_o <= {24'h000000, rx_en_q, tx_empty, txthr_q, tx_room, to_q,
                                       ~rx_empty & rx_head[8], ~rx_empty & rx_head[9], rx_thr};
               default: dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // usrt_core
`default_nettype wire

/* hdl/usrt_defines.vh */
// constants for the serial receiver-transmitter register model
`ifndef USRT_DEFINES_VH
`define USRT_DEFINES_VH
// =============================================
// register byte offsets (word aligned)
`define USRT_A_DATA 6'h00
`define USRT_A_IER 6'h04
`define USRT_A_IID 6'h08
`define USRT_A_LCR 6'h0C
`define USRT_A_MCR 6'h10
`define USRT_A_LSR 6'h14
`define USRT_A_MSR 6'h18
`define USRT_A_CTL 6'h1C
`define USRT_A_STAT 6'h20
`define USRT_A_BMP 6'h24
`define USRT_A_BMC 6'h28
// =============================================
// field positions
`define USRT_LCR_STOP 2
`define USRT_LCR_PEN 3
`define USRT_LCR_EPS 4
`define USRT_LCR_STICK 5
`define USRT_LCR_BRK 6
`define USRT_LCR_DLAB 7
`define USRT_MCR_DTR 0
`define USRT_MCR_RTS 1
`define USRT_MCR_LOOP 4
`define USRT_CTL_RXINT 0
`define USRT_CTL_TXINT 1
`define USRT_CTL_RST 7
`define USRT_STAT_RXEN 7
`define USRT_BMC_MARK 0
// interrupt enable bits
`define USRT_IE_RXT 0
`define USRT_IE_TXT 1
`define USRT_IE_LS 2
`define USRT_IE_MS 3
`define USRT_IE_TO 4
`define USRT_IE_SC 5
`define USRT_IE_TSE 6
// =============================================
// cause codes in bits 3:1, bit 0 high means nothing pending
`define USRT_ID_LS 3'h3
`define USRT_ID_TO 3'h6
`define USRT_ID_RXT 3'h2
`define USRT_ID_TXT 3'h1
`define USRT_ID_TSE 3'h5
`define USRT_ID_MS 3'h0
// =============================================
// reset values and timing
`define USRT_RST_8 8'h00
`define USRT_RST_DIV 16'h0001
`define USRT_OVS_LAST 4'hF
`define USRT_OVS_MID 4'h7
`define USRT_RX_TIMEOUT 2048
`endif

/* bench/usrt_chk.sv */
// assertion checker for the serial unit register model
`timescale 1ns/1ps
`default_nettype none
`include "usrt_defines.vh"
module usrt_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // line side
   input wire logic txd_o,
   input wire logic dtr_n_o,
   input wire logic irq_o
);
   logic req;
   logic wr;
   logic dlab_q;
   assign req = cyc_i && stb_i && !ack_o;
   assign wr = req && we_i && sel_i[0];
   // ==========
   // divisor access follows line control writes; unit reset clears it
   always @(posedge clk_i)
   begin
      if (rst_i || (wr && adr_i == `USRT_A_CTL && dat_i[7]))
         dlab_q <= 1'b0;
      else if (wr && adr_i == `USRT_A_LCR)
         dlab_q <= dat_i[7];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========
   ack_next_a: assert property (req |=> ack_o)
      else $error("request not acknowledged next cycle");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   data_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
      else $error("read data upper bytes not zero");
   reset_pins_a: assert property ($fell(rst_i) |-> txd_o && dtr_n_o && !ack_o && !irq_o)
      else $error("outputs not idle after reset");
   dtr_drive_a: assert property (
      wr && adr_i == `USRT_A_MCR && dat_i[0] && !dat_i[4] |-> ##[1:3] !dtr_n_o)
      else $error("terminal ready not driven");
   ier_gate_a: assert property (
      wr && adr_i == `USRT_A_IER && !dlab_q && dat_i[6:0] == 7'h00 |=> !irq_o)
      else $error("interrupt not masked");
   break_drive_a: assert property (
      wr && adr_i == `USRT_A_LCR && dat_i[6] && !dtr_n_o |-> ##[1:3] !txd_o)
      else $error("break not driven");
   unit_reset_a: assert property (
      wr && adr_i == `USRT_A_CTL && dat_i[7] |-> ##[1:3] !irq_o)
      else $error("unit reset left interrupt");
endmodule // usrt_chk
`default_nettype wire

/* bench/usrt_term.sv */
// serial terminal model facing the unit
`timescale 1ns/1ps
`default_nettype none
module usrt_term #(
   parameter BIT_CYC = 128
) (
   // clock
   input wire logic clk_i,
   // serial line
   input wire logic txd_i,
   output logic rxd_o
);
   logic [9:0] got[$];
   logic [9:0] f;
   integer i;
   // ==========
   // idle line stays high; frames go out lsb first
   initial
   begin
      rxd_o = 1'b1;
   end
   task send(input logic [9:0] fr);
      integer k;
      begin
         for (k = 0; k < 10; k++)
         begin
            rxd_o <= fr[k];
            repeat (BIT_CYC) @(posedge clk_i);
         end
      end
   endtask
   // ==========
   // mid-bit sampling; raw frames keep the start bit for the bench
   always
   begin
      @(negedge txd_i);
      repeat (BIT_CYC / 2) @(posedge clk_i);
      for (i = 0; i < 10; i++)
      begin
         f[i] = txd_i;
         if (i < 9)
            repeat (BIT_CYC) @(posedge clk_i);
      end
      got.push_back(f);
   end
endmodule // usrt_term
`default_nettype wire

/* bench/usrt_programming_model_tb.sv */
// self-checking bench for the serial unit register model
`timescale 1ns/1ps
`default_nettype none
`include "usrt_defines.vh"
module usrt_programming_model_tb;
   logic clk_i, rst_i, cyc, stb, we, bclk, rxd, cts_n, dsr_n;
   logic [5:0] adr;
   logic [3:0] sel;
   logic [31:0] dw;
   wire [31:0] dr;
   wire ack_o, txd_o, dtr_n_o, rts_n_o, irq_o;
   logic [7:0] r, d, c;
   logic [9:0] txq[$];
   logic [7:0] rxq[$];
   integer num_errors, checked, n, i;
   usrt_core #(.DEPTH(16), .AW(4), .TIMEOUT(8)) u_usrt_core (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dw), .dat_o(dr), .ack_o, .baud_source_clock_i(bclk),
      .rx_clk_i(1'b0), .rxd_i(rxd), .cts_n_i(cts_n), .dsr_n_i(dsr_n), .txd_o, .dtr_n_o, .rts_n_o, .irq_o);
   usrt_term #(.BIT_CYC(128)) u_usrt_term (.clk_i, .txd_i(txd_o), .rxd_o(rxd));
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // baud source at 5 MHz, phase unrelated to the bus clock
   initial
   begin
      bclk = 1'b0;
      #7 forever #100 bclk = ~bclk;
   end
   // ==========
   task give_verdict;
      begin
         $display("errors %0d checks %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input logic [9:0] got, input logic [9:0] exp);
      begin
         checked++;
         if (got !== exp)
         begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task tmo;
      begin
         num_errors++;
         $display("Error at %0t: wait ran out", $time);
         give_verdict;
      end
   endtask
   // classic single cycle; ack sampled at rising edges only
   task wb(input logic w, input logic [5:0] a, input logic [7:0] v);
      integer k;
      begin
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         dw <= {24'h000000, v};
         k = 0;
         do
         begin
            @(posedge clk_i);
            k++;
         end
         while (ack_o !== 1'b1 && k < 40);
         if (ack_o !== 1'b1)
            tmo;
         r = dr[7:0];
         cyc <= 1'b0;
         stb <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task rd(input logic [5:0] a, input logic [7:0] e);
      begin
         wb(1'b0, a, 8'h00);
         chk(r, e);
      end
   endtask
   // start, data lsb first, even parity for seven bits, one stop
   function automatic logic [9:0] fr(input logic [7:0] v, input logic sev);
      begin
         if (sev)
            fr = {1'b1, ^v[6:0], v[6:0], 1'b0};
         else
            fr = {1'b1, v, 1'b0};
      end
   endfunction
   // ==========
   initial
   begin
      num_errors = 0;
      checked = 0;
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 6'h00;
      sel = 4'hF;
      cts_n = 1'b1;
      dsr_n = 1'b1;
      dw = 32'h00000000;
      r = 8'($urandom(32'h5000f56e));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      d = 8'($urandom_range(127, 0));
      c = 8'($urandom);
      wb(1'b1, `USRT_A_IER, d);
      rd(`USRT_A_IER, d);
      wb(1'b1, `USRT_A_MCR, c);
      rd(`USRT_A_MCR, c & 8'h13);
      wb(1'b1, `USRT_A_MCR, 8'h03);
      chk(dtr_n_o, 1'b0);
      chk(rts_n_o, 1'b0);
      wb(1'b1, `USRT_A_LCR, 8'h80);
      // 5 MHz source over 16 x 312500 baud gives one
      wb(1'b1, `USRT_A_DATA, 8'h01);
      wb(1'b1, `USRT_A_IER, 8'h00);
      rd(`USRT_A_DATA, 8'h01);
      rd(`USRT_A_IER, 8'h00);
      wb(1'b1, `USRT_A_LCR, 8'h1A);
      rd(`USRT_A_IER, d);
      rd(`USRT_A_LCR, 8'h1A);
      rd(6'h3C, 8'h00);
      wb(1'b1, `USRT_A_CTL, 8'h3B);
      rd(`USRT_A_CTL, 8'h3B);
      // modem lines go active: both change flags and their interrupt follow
      wb(1'b1, `USRT_A_IER, 8'h08);
      cts_n <= 1'b0;
      dsr_n <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(`USRT_A_IID, 8'h00);
      rd(`USRT_A_MSR, 8'h33);
      rd(`USRT_A_MSR, 8'h30);
      rd(`USRT_A_IID, 8'h01);
      wb(1'b1, `USRT_A_IER, 8'h00);
      $display("test registers done");
      // break makes a junk frame at the terminal, so drop it after
      wb(1'b1, `USRT_A_LCR, 8'h5A);
      repeat (4) @(posedge clk_i);
      chk(txd_o, 1'b0);
      wb(1'b1, `USRT_A_LCR, 8'h1A);
      repeat (1500) @(posedge clk_i);
      u_usrt_term.got.delete();
      n = 0;
      while (n < 40)
      begin
         wb(1'b0, `USRT_A_STAT, 8'h00);
         if (r[4] !== 1'b1)
            break;
         c = 8'($urandom);
         wb(1'b1, `USRT_A_DATA, c);
         txq.push_back(fr(c, 1'b1));
         n++;
      end
      chk(n >= 16 && n <= 17, 1'b1);
      wb(1'b1, `USRT_A_IER, 8'h02);
      n = 0;
      while (irq_o !== 1'b1 && n < 40000)
      begin
         @(posedge clk_i);
         n++;
      end
      if (irq_o !== 1'b1)
         tmo;
      wb(1'b0, `USRT_A_IID, 8'h00);
      chk(r[3:0], 4'h2);
      n = 0;
      while (u_usrt_term.got.size() < txq.size() && n < 40000)
      begin
         @(posedge clk_i);
         n++;
      end
      if (u_usrt_term.got.size() < txq.size())
         tmo;
      foreach (txq[i]) chk(u_usrt_term.got[i], txq[i]);
      wb(1'b1, `USRT_A_IER, 8'h00);
      $display("test transmit done");
      wb(1'b1, `USRT_A_LCR, 8'h03);
      // zero is kept out: an all-zero frame counts as break and is not stored
      c = 8'($urandom_range(127, 1));
      wb(1'b1, `USRT_A_BMP, c);
      wb(1'b1, `USRT_A_BMC, 8'h01);
      wb(1'b1, `USRT_A_STAT, 8'h80);
      wb(1'b1, `USRT_A_IER, 8'h01);
      for (i = 0; i < 3; i++)
      begin
         d = (i == 1) ? c : c ^ 8'(8'h81 + i);
         rxq.push_back(d);
         u_usrt_term.send(fr(d, 1'b0));
      end
      n = 0;
      r = 8'h00;
      while (r[0] !== 1'b1 && n < 200)
      begin
         wb(1'b0, `USRT_A_STAT, 8'h00);
         n++;
      end
      if (r[0] !== 1'b1)
         tmo;
      chk(r[0], 1'b1);
      wb(1'b0, `USRT_A_IID, 8'h00);
      chk(r[3:0], 4'h4);
      for (i = 0; i < 3; i++)
      begin
         d = rxq.pop_front();
         wb(1'b0, `USRT_A_STAT, 8'h00);
         chk(r[2], d[6:0] == c[6:0]);
         rd(`USRT_A_DATA, d);
      end
      // parity fault on a lone character, then let it sit past the timeout
      wb(1'b1, `USRT_A_LCR, 8'h1A);
      d = (c ^ 8'h04) & 8'h7F;
      u_usrt_term.send(fr(d, 1'b1) ^ 10'h100);
      repeat (300) @(posedge clk_i);
      wb(1'b0, `USRT_A_STAT, 8'h00);
      chk(r & 8'h0F, 8'h0A);
      rd(`USRT_A_DATA, d);
      wb(1'b0, `USRT_A_STAT, 8'h00);
      chk(r[3:0], 4'h0);
      $display("test receive done");
      wb(1'b1, `USRT_A_CTL, 8'h80);
      repeat (2) @(posedge clk_i);
      rd(`USRT_A_LCR, 8'h00);
      rd(`USRT_A_CTL, 8'h00);
      $display("test unit reset done");
      give_verdict;
   end
endmodule // usrt_programming_model_tb
bind usrt_core usrt_chk u_usrt_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
   .ack_o, .txd_o, .dtr_n_o, .irq_o);
`default_nettype wire
